// ---- logic/adc_scan_defines.svh ----
`ifndef ADC_SCAN_DEFINES_SVH
`define ADC_SCAN_DEFINES_SVH

// Channel selector codes.
`define SEL_PEAK_SCAN 5'h06
`define SEL_FIRST_OUTPUT 5'h08

// Scan geometry.
`define OUTPUT_COUNT 24
`define GROUP_SIZE 3
`define LAST_GROUP 3'h7
`define LAST_SLOT 2'h2

// Clock rate and timing figures.
`define CLK_MHZ 200
`define CONV_TIME_NS 2000
`define BLANK_STEP_NS 1000
`define ERR_PULSE_US 50
`define CONV_CYCLES ((`CONV_TIME_NS * `CLK_MHZ) / 1000)
`define BLANK_STEP_CYCLES ((`BLANK_STEP_NS * `CLK_MHZ) / 1000)
`define ERR_PULSE_CYCLES (`ERR_PULSE_US * `CLK_MHZ)
`define CONV_PER_CHECK 3

// Low-supply threshold encoding: volts = code + base.
`define LOWSUP_BASE_V 6'h04

// Reset value and counter saturation limit.
`define RST_POWERON_FLAG 1'b1
`define CNT_SAT 16'hFFFF

`endif

// ---- logic/adc_scan_pkg.sv ----
package adc_scan_pkg;
  `include "adc_scan_defines.svh"

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PERIOD_SYNC = 3'b001,
    ST_PERIOD_COUNT = 3'b010,
    ST_ON_WAIT = 3'b011,
    ST_CONVERT = 3'b100,
    ST_GROUP_WAIT = 3'b101
  } scan_state_t;

  typedef struct packed {
    logic low_supply;
    logic supply_uv;
    logic ref_fault;
    logic prethermal;
  } fault_in_t;

  typedef struct packed {
    logic poweron;
    logic low_supply;
    logic supply_uv;
    logic ref_fault;
    logic prethermal;
    logic summary;
  } fault_flags_t;

  typedef struct packed {
    scan_state_t state;
    logic scan;
    logic [4:0] chan;
    logic [4:0] adc_chan;
    logic adc_start;
    logic [2:0] group;
    logic [1:0] slot;
    logic [15:0] period_cnt;
    logic [15:0] on_cnt;
    logic [7:0] peak;
    logic [7:0] result;
    logic done;
    logic adc_err;
    fault_flags_t flags;
    fault_in_t prev;
    logic err_oe;
    logic [5:0] lowsup_volts;
  } ctl_state_t;

  typedef struct packed {
    logic [13:0] remain;
  } pulse_state_t;
endpackage : adc_scan_pkg

// ---- logic/err_pulse_timer.sv ----
`timescale 1ns/10ps
`include "adc_scan_defines.svh"
// Counts out one error-pin pulse of a fixed number of clock cycles.
module err_pulse_timer
  import adc_scan_pkg::*;
#(
  parameter int unsigned CYCLES = `ERR_PULSE_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic fire,
  output logic busy
);
  pulse_state_t s;
  pulse_state_t next_s;

  // A new event reloads the full length; otherwise count down to idle.
  always_comb begin
    next_s = s;
    if (fire) begin
      next_s.remain = 14'(CYCLES);
    end else if (s.remain != 14'h0000) begin
      next_s.remain = s.remain - 14'h0001;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  assign busy = (s.remain != 14'h0000);
endmodule : err_pulse_timer

// ---- logic/adc_scan_fault.sv ----
`timescale 1ns/10ps
`include "adc_scan_defines.svh"
// Operation
// R1: Output measurement waits the blanking delay after the channel turns on.
// R2: Host keeps on-pulses longer than blanking plus three conversions.
// R3: Disabled output channel is sampled at once, in the off state.
// R4: Host may force full duty when the dimming period is too short.
// R5: Selector code 06h starts auto scan; peak lands in the result register.
// R6: Peak result is valid only after nine dimming cycles.
// R7: Scan measures one three-output group per dimming cycle, skipping disabled ones.
// R8: After eight groups the done flag sets and the scan halts.
// R9: Result read clears done; with selector 06h it restarts the scan.
// R10: Selector write clears done and restarts conversion.
// R11: Too-short dimming period stops measuring and sets the error flag.
// R12: Error flag clears only by a fault-clear command.
// R13: Faults are only reported, except undervoltage conditions.
// R14: Power-on reset leaves power-on and summary flags set.
// R15: Power-on clear command clears power-on and summary flags.
// R16: Low supply gives one 50 us error pulse and latches its flags.
// R17: Low-supply flags clear by fault-clear once supply has recovered.
// R18: Open and single-short detection are disabled while supply is low.
// R19: Low-supply threshold code spans 4 V to 35 V in 1 V steps.
// R20: Supply undervoltage holds the error pin low and disables outputs.
// R21: Reference fault holds the error pin low until it recovers.
// R22: Pre-thermal warning gives one 50 us pulse and latches its flags.
// R23: Selector write starts a one-shot conversion that loads the result.
// R24: Error pin sinks for steady faults or while a pulse runs.
// R25: Latched flags stay set while their condition persists.
module adc_scan_fault
  import adc_scan_pkg::*;
#(
  parameter int unsigned ERR_PULSE_CYCLES = `ERR_PULSE_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic sel_wr,
  input wire logic [4:0] sel_data,
  input wire logic result_rd,
  output logic [7:0] result,
  output logic conversion_done_flag,
  output logic conversion_error_flag,
  input wire logic fault_clear_cmd,
  input wire logic poweron_clear_cmd,
  input wire logic [3:0] blank_time,
  input wire logic [23:0] channel_output_enable,
  input wire logic [23:0] channel_on,
  input wire logic dim_cycle_start,
  output logic adc_start,
  output logic [4:0] adc_channel,
  input wire logic adc_done,
  input wire logic [7:0] adc_value,
  input wire fault_in_t fault_in,
  input wire logic [4:0] low_supply_threshold,
  output logic [5:0] low_supply_volts,
  output logic open_detect_enable,
  output logic single_short_detect_enable,
  output logic outputs_disable,
  output fault_flags_t fault_flags,
  input wire logic err_pin_in,
  output logic err_pin_out,
  output logic err_pin_oe
);
  ctl_state_t s;
  ctl_state_t next_s;
  logic [31:0] on_vec;
  logic [31:0] en_vec;
  logic [4:0] cur;
  logic [15:0] blank_need;
  logic [15:0] min_period;
  logic trigger;
  logic period_short;
  logic done_set;
  logic err_set;
  logic pulse_fire;
  logic pulse_busy;

  // Maps a scan group and slot onto the output channel index.
  function automatic logic [4:0] out_index(input logic [2:0] g, input logic [1:0] sl);
    out_index = 5'({2'b00, g} * 5'(`GROUP_SIZE) + {3'b000, sl});
  endfunction : out_index

  // True when a selector code addresses a single output channel.
  function automatic logic is_output(input logic [4:0] code);
    is_output = (code >= `SEL_FIRST_OUTPUT);
  endfunction : is_output

  // Padded channel vectors keep any 5-bit index in range.
  assign on_vec = {8'h00, channel_on};
  assign en_vec = {8'h00, channel_output_enable};
  assign cur = s.scan ? out_index(s.group, s.slot) : 5'(s.chan - `SEL_FIRST_OUTPUT);

  // Blanking delay and the least dimming period that leaves room for measurement.
  assign blank_need = 16'(blank_time) * 16'(`BLANK_STEP_CYCLES); // R1
  assign min_period = blank_need + 16'(`CONV_PER_CHECK * `CONV_CYCLES); // R11
  // One extra bit keeps a saturated period count from wrapping into a false short period.
  assign period_short = ({1'b0, s.period_cnt} + 17'h00001) < {1'b0, min_period};
  assign trigger = sel_wr || (result_rd && s.chan == `SEL_PEAK_SCAN);
  assign pulse_fire = (fault_in.low_supply && !s.prev.low_supply) // R16
    || (fault_in.prethermal && !s.prev.prethermal); // R22

  // Next-state logic of the conversion sequencer and the fault flags.
  always_comb begin
    next_s = s;
    done_set = 1'b0;
    err_set = 1'b0;
    next_s.adc_start = 1'b0;
    next_s.prev = fault_in;
    next_s.lowsup_volts = 6'(low_supply_threshold) + `LOWSUP_BASE_V; // R19
    if (on_vec[cur]) begin
      next_s.on_cnt = (s.on_cnt == `CNT_SAT) ? s.on_cnt : s.on_cnt + 16'h0001;
    end else begin
      next_s.on_cnt = 16'h0000;
    end
    unique case (s.state)
      ST_IDLE: begin
        next_s.state = ST_IDLE;
      end
      ST_PERIOD_SYNC: begin
        next_s.period_cnt = 16'h0000;
        if (dim_cycle_start) begin // R6
          next_s.state = ST_PERIOD_COUNT;
        end
      end
      ST_PERIOD_COUNT: begin
        if (s.period_cnt != `CNT_SAT) begin
          next_s.period_cnt = s.period_cnt + 16'h0001;
        end
        if (dim_cycle_start) begin
          if (period_short) begin
            err_set = 1'b1; // R11
            next_s.state = ST_IDLE;
          end else if (s.scan || (is_output(s.chan) && en_vec[cur])) begin
            next_s.state = ST_ON_WAIT;
          end else begin
            next_s.state = ST_CONVERT; // R3
            next_s.adc_start = 1'b1;
            next_s.adc_chan = s.chan;
          end
        end
      end
      ST_ON_WAIT: begin
        if (s.scan && !en_vec[cur]) begin
          // A disabled channel gives up its slot.
          if (s.slot == `LAST_SLOT) begin // R7
            next_s.slot = 2'h0;
            if (s.group == `LAST_GROUP) begin
              next_s.result = s.peak; // R8
              done_set = 1'b1;
              next_s.state = ST_IDLE;
            end else begin
              next_s.group = s.group + 3'h1;
              next_s.state = ST_GROUP_WAIT;
            end
          end else begin
            next_s.slot = s.slot + 2'h1;
          end
        end else if (on_vec[cur] && s.on_cnt >= blank_need) begin
          next_s.state = ST_CONVERT; // R1
          next_s.adc_start = 1'b1;
          next_s.adc_chan = cur + `SEL_FIRST_OUTPUT;
        end
      end
      ST_CONVERT: begin
        if (adc_done) begin
          if (!s.scan) begin
            next_s.result = adc_value; // R23
            done_set = 1'b1;
            next_s.state = ST_IDLE;
          end else begin
            if (adc_value > s.peak) begin
              next_s.peak = adc_value; // R5
            end
            next_s.state = ST_ON_WAIT;
            if (s.slot == `LAST_SLOT) begin
              next_s.slot = 2'h0;
              if (s.group == `LAST_GROUP) begin
                next_s.result = (adc_value > s.peak) ? adc_value : s.peak; // R8
                done_set = 1'b1;
                next_s.state = ST_IDLE;
              end else begin
                next_s.group = s.group + 3'h1; // R7
                next_s.state = ST_GROUP_WAIT;
              end
            end else begin
              next_s.slot = s.slot + 2'h1;
            end
          end
        end
      end
      ST_GROUP_WAIT: begin
        if (dim_cycle_start) begin
          next_s.state = ST_ON_WAIT; // R7
        end
      end
      default: begin
        next_s.state = ST_IDLE;
      end
    endcase
    // A selector write, or a result read while scanning, starts over.
    if (trigger) begin // R9
      next_s.state = ST_PERIOD_SYNC; // R10
      next_s.scan = sel_wr ? (sel_data == `SEL_PEAK_SCAN) : 1'b1; // R5
      next_s.group = 3'h0;
      next_s.slot = 2'h0;
      next_s.peak = 8'h00;
      next_s.adc_start = 1'b0;
    end
    if (sel_wr) begin
      next_s.chan = sel_data; // R23
    end
    // Done clears on any selector write or result read; completion wins.
    next_s.done = done_set || (s.done && !(sel_wr || result_rd)); // R9
    next_s.adc_err = err_set || (s.adc_err && !fault_clear_cmd); // R12
    // Flags hold while their condition stands; clear commands act otherwise.
    next_s.flags.poweron = s.flags.poweron && !poweron_clear_cmd; // R15
    next_s.flags.low_supply = fault_in.low_supply // R25
      || (s.flags.low_supply && !fault_clear_cmd); // R17
    next_s.flags.supply_uv = fault_in.supply_uv
      || (s.flags.supply_uv && !fault_clear_cmd); // R20
    next_s.flags.ref_fault = fault_in.ref_fault
      || (s.flags.ref_fault && !fault_clear_cmd); // R21
    next_s.flags.prethermal = fault_in.prethermal
      || (s.flags.prethermal && !fault_clear_cmd); // R22
    next_s.flags.summary = next_s.flags.poweron || next_s.flags.low_supply
      || next_s.flags.supply_uv || next_s.flags.ref_fault || next_s.flags.prethermal;
    // Steady sink for undervoltage and reference faults, pulse otherwise.
    next_s.err_oe = fault_in.supply_uv || fault_in.ref_fault || pulse_busy; // R24
  end

  // State register; power-on reset leaves power-on and summary flags set.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.state <= ST_IDLE;
      s.lowsup_volts <= `LOWSUP_BASE_V;
      s.flags.poweron <= `RST_POWERON_FLAG; // R14
      s.flags.summary <= `RST_POWERON_FLAG;
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  // Times the single error pulse of low-supply and pre-thermal events.
  err_pulse_timer #(
    .CYCLES(ERR_PULSE_CYCLES)
  ) u_pulse (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .fire(pulse_fire && clk_en),
    .busy(pulse_busy)
  );

  // Register-driven outputs; the error pin output is tied low.
  assign result = s.result;
  assign conversion_done_flag = s.done;
  assign conversion_error_flag = s.adc_err;
  assign adc_start = s.adc_start;
  assign adc_channel = s.adc_chan;
  assign low_supply_volts = s.lowsup_volts;
  assign open_detect_enable = !s.prev.low_supply; // R18
  assign single_short_detect_enable = !s.prev.low_supply; // R18
  assign outputs_disable = s.prev.supply_uv; // R13
  assign fault_flags = s.flags;
  assign err_pin_out = 1'b0;
  assign err_pin_oe = s.err_oe;

  // Checks.
  sequence s_pulse_start;
    (pulse_fire && clk_en) ##1 clk_en;
  endsequence

  property p_blank_wait;
    @(posedge clk_sys) disable iff (!rst_n)
    (clk_en && s.state == ST_ON_WAIT && !trigger && next_s.state == ST_CONVERT)
    |-> s.on_cnt >= blank_need;
  endproperty
  a_blank_wait: assert property (p_blank_wait) else $error("conversion before blanking"); // R1

  property p_off_sample;
    @(posedge clk_sys) disable iff (!rst_n)
    (clk_en && s.state == ST_PERIOD_COUNT && dim_cycle_start && !period_short && !trigger
      && !s.scan && is_output(s.chan) && !en_vec[cur]) |=> (s.state == ST_CONVERT && adc_start);
  endproperty
  a_off_sample: assert property (p_off_sample) else $error("off channel not sampled"); // R3

  property p_scan_entry;
    @(posedge clk_sys) disable iff (!rst_n)
    (clk_en && sel_wr && sel_data == `SEL_PEAK_SCAN) |=> (s.scan && s.state == ST_PERIOD_SYNC);
  endproperty
  a_scan_entry: assert property (p_scan_entry) else $error("scan not entered"); // R5

  property p_scan_done;
    @(posedge clk_sys) disable iff (!rst_n)
    ($rose(s.done) && s.scan) |-> ($past(s.group) == `LAST_GROUP && s.state == ST_IDLE);
  endproperty
  a_scan_done: assert property (p_scan_done) else $error("scan ended early"); // R8

  property p_group_step;
    @(posedge clk_sys) disable iff (!rst_n)
    (clk_en && s.state == ST_GROUP_WAIT && dim_cycle_start && !trigger) |=> s.state == ST_ON_WAIT;
  endproperty
  a_group_step: assert property (p_group_step) else $error("group not advanced"); // R7

  property p_read_restart;
    @(posedge clk_sys) disable iff (!rst_n)
    (clk_en && result_rd && s.chan == `SEL_PEAK_SCAN && !done_set)
    |=> (!s.done && s.state == ST_PERIOD_SYNC);
  endproperty
  a_read_restart: assert property (p_read_restart) else $error("read did not restart"); // R9

  property p_write_clears;
    @(posedge clk_sys) disable iff (!rst_n)
    (clk_en && sel_wr && !done_set) |=> !s.done;
  endproperty
  a_write_clears: assert property (p_write_clears) else $error("write left done set"); // R10

  property p_short_error;
    @(posedge clk_sys) disable iff (!rst_n)
    (clk_en && s.state == ST_PERIOD_COUNT && dim_cycle_start && period_short && !trigger)
    |=> (s.adc_err && s.state == ST_IDLE);
  endproperty
  a_short_error: assert property (p_short_error) else $error("short period missed"); // R11

  property p_error_hold;
    @(posedge clk_sys) disable iff (!rst_n)
    (s.adc_err && !fault_clear_cmd) |=> s.adc_err;
  endproperty
  a_error_hold: assert property (p_error_hold) else $error("error flag lost"); // R12

  property p_pulse;
    @(posedge clk_sys) disable iff (!rst_n)
    s_pulse_start |=> err_pin_oe;
  endproperty
  a_pulse: assert property (p_pulse) else $error("error pulse missing"); // R16

  property p_steady_sink;
    @(posedge clk_sys) disable iff (!rst_n)
    (clk_en && fault_in.supply_uv) |=> (err_pin_oe && outputs_disable && s.flags.supply_uv);
  endproperty
  a_steady_sink: assert property (p_steady_sink) else $error("undervoltage not held"); // R20

  property p_flag_persist;
    @(posedge clk_sys) disable iff (!rst_n)
    (clk_en && fault_in.low_supply) |=> (s.flags.low_supply && s.flags.summary);
  endproperty
  a_flag_persist: assert property (p_flag_persist) else $error("flag cleared under fault"); // R25

  property p_por_clear;
    @(posedge clk_sys) disable iff (!rst_n)
    (clk_en && poweron_clear_cmd) |=> !s.flags.poweron;
  endproperty
  a_por_clear: assert property (p_por_clear) else $error("power-on flag kept"); // R15
endmodule : adc_scan_fault

// ---- tb/sar_adc_model.sv ----
`timescale 1ns/10ps
// Behavioural converter: fixed conversion time, one-cycle done pulse.
module sar_adc_model #(
  parameter int CONV = 400
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic adc_start,
  input wire logic [4:0] adc_channel,
  output logic adc_done,
  output logic [7:0] adc_value
);
  int cnt;
  logic [4:0] chan;

  // Data is only valid with done; otherwise it toggles so stale codes never look valid.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      chan <= 5'h00;
      adc_done <= 1'b0;
      adc_value <= 8'hA5;
    end else begin
      adc_done <= 1'b0;
      adc_value <= ~adc_value;
      if (adc_start) begin
        cnt <= CONV;
        chan <= adc_channel;
      end else if (cnt == 1) begin
        cnt <= 0;
        adc_done <= 1'b1;
        adc_value <= {chan, 3'h0};
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule : sar_adc_model

// ---- tb/test_adc_scan_fault.sv ----
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin \
  miscompares++; $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); end end
module test_adc_scan_fault;
  import adc_scan_pkg::*;
  localparam int PULSE = 20;
  logic clk_sys = 1'b0, rst_n = 1'b0, sel_wr = 1'b0, result_rd = 1'b0;
  logic fault_clear_cmd = 1'b0, poweron_clear_cmd = 1'b0, dim_cycle_start, adc_start, adc_done;
  logic [4:0] sel_data = 5'h00, low_supply_threshold = 5'h00, adc_channel;
  logic [3:0] blank_time = 4'h1;
  logic [23:0] channel_output_enable = 24'hFFFFFF, channel_on;
  logic [7:0] adc_value, result;
  logic conversion_done_flag, conversion_error_flag, open_detect_enable, err_pin_out;
  logic single_short_detect_enable, outputs_disable, err_pin_oe, scanning = 1'b0, clk_en = 1'b1;
  logic [5:0] low_supply_volts;
  fault_in_t fault_in = '0;
  fault_flags_t fault_flags;
  int miscompares = 0, total_checks = 0, cycles = 0, dim_cnt = 0, dim_period = 1500;
  int on_len = 1450, dim_starts = 0, starts = 0;

  always #2.5 clk_sys = ~clk_sys;

  // Dimming timing: period start pulse and on window change at the falling edge.
  always @(negedge clk_sys) dim_cnt <= (dim_cnt + 1 >= dim_period) ? 0 : dim_cnt + 1;
  assign dim_cycle_start = (dim_cnt == 0);
  assign channel_on = (dim_cnt < on_len) ? 24'hFFFFFF : 24'h000000;

  adc_scan_fault #(.ERR_PULSE_CYCLES(PULSE)) i_adc_scan_fault (.clk_sys(clk_sys),
    .rst_n(rst_n), .clk_en(clk_en), .sel_wr(sel_wr), .sel_data(sel_data),
    .result_rd(result_rd), .result(result), .conversion_done_flag(conversion_done_flag),
    .conversion_error_flag(conversion_error_flag), .fault_clear_cmd(fault_clear_cmd),
    .poweron_clear_cmd(poweron_clear_cmd), .blank_time(blank_time),
    .channel_output_enable(channel_output_enable), .channel_on(channel_on),
    .dim_cycle_start(dim_cycle_start), .adc_start(adc_start), .adc_channel(adc_channel),
    .adc_done(adc_done), .adc_value(adc_value), .fault_in(fault_in),
    .low_supply_threshold(low_supply_threshold), .low_supply_volts(low_supply_volts),
    .open_detect_enable(open_detect_enable),
    .single_short_detect_enable(single_short_detect_enable),
    .outputs_disable(outputs_disable), .fault_flags(fault_flags),
    .err_pin_in(err_pin_oe ? err_pin_out : 1'b1), .err_pin_out(err_pin_out),
    .err_pin_oe(err_pin_oe));

  sar_adc_model i_sar_adc_model (.clk_sys(clk_sys), .rst_n(rst_n), .adc_start(adc_start),
    .adc_channel(adc_channel), .adc_done(adc_done), .adc_value(adc_value));

  // Watches every conversion start: blanking on enabled outputs, skipping during scan.
  always @(posedge clk_sys) begin
    cycles++;
    if (dim_cycle_start) dim_starts++;
    if (adc_start === 1'b1) begin
      starts++;
      if (adc_channel >= 5'h08 && channel_output_enable[adc_channel - 5'h08])
        `CHK("blank wait", 1'b1, dim_cnt >= blank_time * 200)
      if (scanning && adc_channel >= 5'h08)
        `CHK("skip disabled", 1'b1, channel_output_enable[adc_channel - 5'h08])
    end
    if (cycles == 100000) begin
      miscompares++;
      summarize();
    end
  end

  task automatic pulse(ref logic s);
    @(negedge clk_sys);
    s = 1'b1;
    @(negedge clk_sys);
    s = 1'b0;
  endtask : pulse

  task automatic sel_write(input logic [4:0] code);
    sel_data = code;
    pulse(sel_wr);
  endtask : sel_write

  task automatic wait_done(input int lim);
    for (int i = 0; i < lim && conversion_done_flag !== 1'b1; i++) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : wait_done

  task automatic wait_cycles(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : wait_cycles

  // Reset values, power-on clear and threshold encoding at both ends.
  task automatic reset_test;
    `CHK("poweron flag", 1'b1, fault_flags.poweron)
    `CHK("summary flag", 1'b1, fault_flags.summary)
    pulse(poweron_clear_cmd);
    wait_cycles(2);
    `CHK("poweron clear", 2'b00, {fault_flags.poweron, fault_flags.summary})
    low_supply_threshold = 5'h1F;
    wait_cycles(2);
    `CHK("volts top", 6'h23, low_supply_volts)
    low_supply_threshold = 5'h00;
    wait_cycles(2);
    `CHK("volts base", 6'h04, low_supply_volts)
  endtask : reset_test

  // One-shot conversions on an enabled output, a disabled output and a supply channel.
  task automatic oneshot_test;
    channel_output_enable = 24'hFFFFFE;
    sel_write(5'h09);
    wait_done(8000);
    `CHK("done on output", 1'b1, conversion_done_flag)
    `CHK("result on output", 8'h48, result)
    sel_write(5'h08);
    `CHK("done cleared", 1'b0, conversion_done_flag)
    wait_done(8000);
    `CHK("done off output", 1'b1, conversion_done_flag)
    `CHK("result off output", 8'h40, result)
    sel_write(5'h01);
    `CHK("done cleared again", 1'b0, conversion_done_flag)
    wait_done(8000);
    `CHK("one-shot result", 8'h08, result)
    `CHK("no error", 1'b0, conversion_error_flag)
  endtask : oneshot_test

  // Dimming period shorter than blanking plus three conversions.
  task automatic period_error_test;
    dim_period = 300;
    on_len = 300;
    sel_write(5'h01);
    wait_cycles(1200);
    `CHK("error set", 1'b1, conversion_error_flag)
    `CHK("no done on error", 1'b0, conversion_done_flag)
    sel_write(5'h02);
    wait_cycles(20);
    `CHK("error kept by write", 1'b1, conversion_error_flag)
    pulse(fault_clear_cmd);
    wait_cycles(2);
    `CHK("error cleared", 1'b0, conversion_error_flag)
    dim_period = 1500;
    on_len = 1450;
  endtask : period_error_test

  // Peak scan: nine periods, 23 enabled outputs, halt, read restarts.
  task automatic scan_test;
    int n0;
    channel_output_enable = 24'h7FFFFF;
    scanning = 1'b1;
    sel_write(5'h06);
    starts = 0;
    n0 = dim_starts;
    while (dim_starts < n0 + 8) @(negedge clk_sys);
    wait_cycles(1400);
    `CHK("done before nine", 1'b0, conversion_done_flag)
    wait_done(3000);
    `CHK("scan done", 1'b1, conversion_done_flag)
    `CHK("scan peak", 8'hF0, result)
    `CHK("scan starts", 23, starts)
    wait_cycles(3000);
    `CHK("scan halted", 23, starts)
    channel_output_enable = 24'hFFFFFF;
    pulse(result_rd);
    `CHK("read clears done", 1'b0, conversion_done_flag)
    wait_done(20000);
    `CHK("rescan done", 1'b1, conversion_done_flag)
    `CHK("rescan peak", 8'hF8, result)
    scanning = 1'b0;
  endtask : scan_test

  // Each fault: pin behaviour, latched flags, clear only after recovery.
  task automatic fault_test;
    int n;
    for (int b = 3; b >= 0; b--) begin
      fault_in = fault_in_t'(4'h1 << b);
      n = 0;
      // The pin is sampled at the falling edge, where the registered drive has settled.
      for (int i = 0; i < 63; i++) begin
        @(negedge clk_sys);
        n += (err_pin_oe === 1'b1) ? 1 : 0;
      end
      `CHK("pin sink cycles", (b == 2 || b == 1) ? 63 : PULSE, n)
      `CHK("flag set", 2'b11, {fault_flags[b + 1], fault_flags.summary})
      `CHK("outputs off", b == 2, outputs_disable)
      `CHK("detect on", b != 3, open_detect_enable & single_short_detect_enable)
      pulse(fault_clear_cmd);
      wait_cycles(2);
      `CHK("flag held", 1'b1, fault_flags[b + 1])
      fault_in = '0;
      wait_cycles(3);
      `CHK("pin released", 1'b0, err_pin_oe)
      `CHK("detect back", 1'b1, open_detect_enable & single_short_detect_enable)
      `CHK("flag latched", 1'b1, fault_flags[b + 1])
      pulse(fault_clear_cmd);
      wait_cycles(2);
      `CHK("flag cleared", 2'b00, {fault_flags[b + 1], fault_flags.summary})
    end
  endtask : fault_test

  // Clock enable low freezes the fault flags and the pin drive.
  task automatic freeze_test;
    clk_en = 1'b0;
    fault_in.ref_fault = 1'b1;
    wait_cycles(4);
    `CHK("frozen flag", 2'b00, {fault_flags.ref_fault, err_pin_oe})
    clk_en = 1'b1;
    wait_cycles(2);
    `CHK("thawed flag", 2'b11, {fault_flags.ref_fault, err_pin_oe})
    fault_in = '0;
    wait_cycles(2);
    pulse(fault_clear_cmd);
    wait_cycles(2);
    `CHK("thawed clear", 1'b0, fault_flags.ref_fault)
  endtask : freeze_test

  task automatic summarize;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize

  initial begin
    repeat (8) @(negedge clk_sys);
    rst_n = 1'b1;
    reset_test();
    oneshot_test();
    period_error_test();
    scan_test();
    fault_test();
    freeze_test();
    summarize();
  end
endmodule : test_adc_scan_fault
